//--- core/tas_defs.vh
// constants for the touch switch sequencer: register map, control word layout, timing counts
`ifndef TAS_DEFS_VH
`define TAS_DEFS_VH

// register byte offsets
`define TAS_REG_CTRL 8'h00
`define TAS_REG_STATUS 8'h04
`define TAS_REG_WORD 8'h08
`define TAS_REG_COUNT 8'h0c

// reset values
`define TAS_CTRL_RST 1'h1
`define TAS_PD_RST 2'h2

// axi responses
`define TAS_RESP_OKAY 2'h0
`define TAS_RESP_SLVERR 2'h2

// control word: bits shifted in after the start bit
`define TAS_WORD_BITS 3'h7
`define TAS_CFG_READY_BIT 3'h5
`define TAS_PD_ALL_ON 2'h3

// channel codes
`define TAS_CH_TEMP0 3'h0
`define TAS_CH_XPOS 3'h1
`define TAS_CH_BAT 3'h2
`define TAS_CH_Z1 3'h3
`define TAS_CH_Z2 3'h4
`define TAS_CH_YPOS 3'h5
`define TAS_CH_TEMP1 3'h7

// reference node selections
`define TAS_REFP_VREF 2'h0
`define TAS_REFP_YP 2'h1
`define TAS_REFP_XP 2'h2
`define TAS_REFN_GND 2'h0
`define TAS_REFN_YN 2'h1
`define TAS_REFN_XN 2'h2

// serial clock falling edges per phase
`define TAS_ACQ_FALLS 4'h3
`define TAS_CONV12_FALLS 4'hc
`define TAS_CONV8_FALLS 4'h8

`endif

//--- core/tas_sync2.v
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module tas_sync2 #(
  parameter W = 2
) (
  input wire aclk, // system clock
  input wire aresetn, // synchronous reset, active low
  input wire [W-1:0] d, // asynchronous inputs
  output wire [W-1:0] q // synchronised outputs
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // first stage feeds only the second stage
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule // tas_sync2

//--- core/tas_touch_seq.v
// touch screen front end sequencer: serial word capture, phase timing, switch and reference control
// Notes on behaviour
// - tracking starts on the falling edge of the fifth serial clock after start
// - both power bits one keeps plate drivers on between conversions
// - back-to-back fifteen clock 12-bit ratiometric words keep drivers on without a gap
// - internal reference enabled exactly when the high power bit is one
// - reference switch opens whenever the internal reference is off
// - single-ended y measurement: x+ to converter, y drivers on, vref/gnd reference
// - single-ended mode turns plate drivers off once acquisition ends
// - ratiometric mode takes reference nodes from the driven plate terminals
// - ratiometric mode keeps drivers on through acquisition and conversion
// - battery divider on only while the battery channel is sampled
// - two temperature diode channels: base bias and multiplied bias
// - power bits come up as low zero, high one until a word loads
// - reference mode bit one selects single-ended, zero differential
`timescale 1ns/1ps
`include "tas_defs.vh"
module tas_touch_seq (
  input wire aclk, // system clock, 10 MHz
  input wire aresetn, // synchronous reset, active low
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte strobes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output wire [1:0] s_axi_bresp, // write response
  output wire s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output wire [31:0] s_axi_rdata, // read data
  output wire [1:0] s_axi_rresp, // read response
  output wire s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire serial_conversion_clock, // host serial clock pin
  input wire serial_data_in, // host serial data pin
  output wire track_en, // high while track-and-hold is tracking
  output wire [2:0] mux_sel, // converter input channel
  output wire drv_xp, // x+ plate driver on
  output wire drv_xn, // x- plate driver on
  output wire drv_yp, // y+ plate driver on
  output wire drv_yn, // y- plate driver on
  output wire [1:0] ref_pos_sel, // positive reference node select
  output wire [1:0] ref_neg_sel, // negative reference node select
  output wire bat_div_en, // battery divide-by-four network on
  output wire temp_bias_base, // diode biased by base current
  output wire temp_bias_mult, // diode biased by multiplied current
  output wire int_ref_en, // internal reference powered
  output wire reference_disconnect_switch // closed (1) ties internal reference to the pin
);
  localparam PH_IDLE = 3'b001;
  localparam PH_ACQ = 3'b010;
  localparam PH_CONV = 3'b100;
  // pin synchronisation
  wire [1:0] pins_s;
  tas_sync2 #(.W(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({serial_conversion_clock, serial_data_in}),
    .q(pins_s)
  );
  wire sclk_s = pins_s[1];
  wire din_s = pins_s[0];
  reg sclk_prev_ff;
  wire sclk_rise = sclk_s & ~sclk_prev_ff;
  wire sclk_fall = ~sclk_s & sclk_prev_ff;
  // software control and word state
  reg seq_enable_ff, rx_busy_ff;
  reg [2:0] rx_bits_ff;
  reg [5:0] shift_ff;
  reg [7:0] word_ff;
  reg [1:0] power_ctrl_ff; // {power_ctrl_high_bit, power_ctrl_low_bit}
  reg [15:0] conv_count_ff;
  // serial word receiver; start is only recognised while idle and enabled
  always @(posedge aclk) begin
    if (!aresetn) begin
      sclk_prev_ff <= 1'b0;
      rx_busy_ff <= 1'b0;
      rx_bits_ff <= 3'h0;
      shift_ff <= 6'h00;
      word_ff <= 8'h00;
      power_ctrl_ff <= `TAS_PD_RST;
    end else begin
      sclk_prev_ff <= sclk_s;
      if (sclk_rise) begin
        if (!rx_busy_ff && seq_enable_ff && din_s) begin
          rx_busy_ff <= 1'b1;
          rx_bits_ff <= 3'h0;
        end else if (rx_busy_ff) begin
          shift_ff <= {shift_ff[4:0], din_s};
          rx_bits_ff <= rx_bits_ff + 3'h1;
          if (rx_bits_ff == `TAS_WORD_BITS - 3'h1) begin
            // last bit in: word complete, power bits take effect
            rx_busy_ff <= 1'b0;
            word_ff <= {1'b1, shift_ff, din_s};
            power_ctrl_ff <= {shift_ff[0], din_s};
          end
        end
      end
    end
  end
  // channel, resolution and reference mode are known once five bits are in
  wire acq_go = sclk_fall & rx_busy_ff & (rx_bits_ff == `TAS_CFG_READY_BIT);
  reg [2:0] phase_ff, ch_ff, nxt_phase, nxt_ch;
  reg [3:0] cnt_ff, nxt_cnt;
  reg ser_ff, mode8_ff, nxt_ser, nxt_mode8, conv_done;
  wire [3:0] conv_len = mode8_ff ? `TAS_CONV8_FALLS : `TAS_CONV12_FALLS;
  // phase sequencing on serial clock falling edges; a new acquisition preempts
  // a running conversion so overlapped words chain with no idle gap
  always @* begin
    nxt_phase = phase_ff;
    nxt_cnt = cnt_ff;
    nxt_ch = ch_ff;
    nxt_ser = ser_ff;
    nxt_mode8 = mode8_ff;
    conv_done = 1'b0;
    if (acq_go) begin
      nxt_phase = PH_ACQ;
      nxt_cnt = 4'h0;
      nxt_ch = shift_ff[4:2];
      nxt_mode8 = shift_ff[1];
      nxt_ser = shift_ff[0];
      conv_done = (phase_ff == PH_CONV) && (cnt_ff == conv_len - 4'h1); // chained word: count the running conversion only if this fall is its last
    end else if (sclk_fall) begin
      case (phase_ff)
        PH_IDLE: nxt_cnt = 4'h0;
        PH_ACQ: begin
          if (cnt_ff == `TAS_ACQ_FALLS - 4'h1) begin
            nxt_phase = PH_CONV;
            nxt_cnt = 4'h0;
          end else begin
            nxt_cnt = cnt_ff + 4'h1;
          end
        end
        PH_CONV: begin
          if (cnt_ff == conv_len - 4'h1) begin
            nxt_phase = PH_IDLE;
            nxt_cnt = 4'h0;
            conv_done = 1'b1;
          end else begin
            nxt_cnt = cnt_ff + 4'h1;
          end
        end
        default: begin
          nxt_phase = PH_IDLE;
          nxt_cnt = 4'h0;
        end
      endcase
    end
  end
  // plate drivers and reference nodes for a channel and reference mode
  reg [3:0] tbl_drv; // {xp, xn, yp, yn}
  reg [1:0] tbl_refp, tbl_refn;
  always @* begin
    tbl_drv = 4'h0;
    tbl_refp = `TAS_REFP_VREF;
    tbl_refn = `TAS_REFN_GND;
    case (nxt_ch)
      `TAS_CH_XPOS: begin
        tbl_drv = 4'b0011;
        if (!nxt_ser) begin
          tbl_refp = `TAS_REFP_YP;
          tbl_refn = `TAS_REFN_YN;
        end
      end
      `TAS_CH_Z1, `TAS_CH_Z2: begin
        tbl_drv = 4'b0110;
        if (!nxt_ser) begin
          tbl_refp = `TAS_REFP_YP;
          tbl_refn = `TAS_REFN_XN;
        end
      end
      `TAS_CH_YPOS: begin
        tbl_drv = 4'b1100;
        if (!nxt_ser) begin
          tbl_refp = `TAS_REFP_XP;
          tbl_refn = `TAS_REFN_XN;
        end
      end
      default: tbl_drv = 4'h0;
    endcase
  end
  // registered front end controls, computed from the next phase so pins
  // change on the same system edge as the phase
  reg [3:0] drv_ff, nxt_drv;
  reg track_ff, bat_ff, tb_base_ff, tb_mult_ff;
  reg [1:0] refp_ff, refn_ff;
  wire sampling = (nxt_phase == PH_ACQ);
  always @* begin
    case (nxt_phase)
      PH_ACQ: nxt_drv = tbl_drv;
      PH_CONV: nxt_drv = nxt_ser ? 4'h0 : tbl_drv;
      PH_IDLE: nxt_drv = (power_ctrl_ff == `TAS_PD_ALL_ON) ? tbl_drv : 4'h0;
      default: nxt_drv = 4'h0;
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      phase_ff <= PH_IDLE;
      cnt_ff <= 4'h0;
      ch_ff <= 3'h0;
      ser_ff <= 1'b1;
      mode8_ff <= 1'b0;
      drv_ff <= 4'h0;
      track_ff <= 1'b0;
      bat_ff <= 1'b0;
      tb_base_ff <= 1'b0;
      tb_mult_ff <= 1'b0;
      refp_ff <= `TAS_REFP_VREF;
      refn_ff <= `TAS_REFN_GND;
      conv_count_ff <= 16'h0000;
    end else begin
      phase_ff <= nxt_phase;
      cnt_ff <= nxt_cnt;
      ch_ff <= nxt_ch;
      ser_ff <= nxt_ser;
      mode8_ff <= nxt_mode8;
      drv_ff <= nxt_drv;
      track_ff <= sampling;
      bat_ff <= sampling & nxt_ser & (nxt_ch == `TAS_CH_BAT);
      tb_base_ff <= sampling & nxt_ser & (nxt_ch == `TAS_CH_TEMP0);
      tb_mult_ff <= sampling & nxt_ser & (nxt_ch == `TAS_CH_TEMP1);
      refp_ff <= tbl_refp;
      refn_ff <= tbl_refn;
      if (conv_done) begin
        conv_count_ff <= conv_count_ff + 16'h0001;
      end
    end
  end
  assign track_en = track_ff;
  assign mux_sel = ch_ff;
  assign drv_xp = drv_ff[3];
  assign drv_xn = drv_ff[2];
  assign drv_yp = drv_ff[1];
  assign drv_yn = drv_ff[0];
  assign ref_pos_sel = refp_ff;
  assign ref_neg_sel = refn_ff;
  assign bat_div_en = bat_ff;
  assign temp_bias_base = tb_base_ff;
  assign temp_bias_mult = tb_mult_ff;
  // reference power and its pin switch follow the high power bit alone
  assign int_ref_en = power_ctrl_ff[1];
  assign reference_disconnect_switch = power_ctrl_ff[1];
  // axi4-lite slave: one write and one read in flight, write answered one cycle after capture, read on the capture edge
  reg awready_ff, wready_ff, aw_have_ff, w_have_ff, bvalid_ff, arready_ff, rvalid_ff, rd_hit;
  reg [7:0] awaddr_ff;
  reg [3:0] wstrb_ff;
  reg [1:0] bresp_ff, rresp_ff;
  reg [31:0] wdata_ff, rdata_ff, rd_val;
  // read decode; reserved bits read as zero
  always @* begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `TAS_REG_CTRL: rd_val = {31'h00000000, seq_enable_ff};
      `TAS_REG_STATUS: rd_val = {24'h000000, cnt_ff, rx_busy_ff, phase_ff};
      `TAS_REG_WORD: rd_val = {16'h0000, 6'h00, power_ctrl_ff, word_ff};
      `TAS_REG_COUNT: rd_val = {16'h0000, conv_count_ff};
      default: rd_hit = 1'b0;
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `TAS_RESP_OKAY;
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= `TAS_RESP_OKAY;
      rdata_ff <= 32'h00000000;
      seq_enable_ff <= `TAS_CTRL_RST;
    end else begin
      if (awready_ff && s_axi_awvalid) begin
        awaddr_ff <= s_axi_awaddr;
        awready_ff <= 1'b0;
        aw_have_ff <= 1'b1;
      end
      if (wready_ff && s_axi_wvalid) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        wready_ff <= 1'b0;
        w_have_ff <= 1'b1;
      end
      // both halves held: commit; status registers ignore writes
      if (aw_have_ff && w_have_ff && !bvalid_ff) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= `TAS_RESP_OKAY;
        case (awaddr_ff)
          `TAS_REG_CTRL: seq_enable_ff <= wstrb_ff[0] ? wdata_ff[0] : seq_enable_ff;
          `TAS_REG_STATUS, `TAS_REG_WORD, `TAS_REG_COUNT: bresp_ff <= `TAS_RESP_OKAY;
          default: bresp_ff <= `TAS_RESP_SLVERR;
        endcase
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
      if (arready_ff && s_axi_arvalid) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_val;
        rresp_ff <= rd_hit ? `TAS_RESP_OKAY : `TAS_RESP_SLVERR;
      end
      if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
endmodule // tas_touch_seq

//--- tb/tas_host_model.sv
// host side model: drives serial clock and data, clock stands low between frames
`timescale 1ns/1ps
module tas_host_model (
  input wire aclk, // system clock
  output logic sclk, // serial clock, idle low
  output logic sdata // serial data
);
  int falls = 0; // falling edges in the current frame
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
  end
  // n bits msb first; half is each clock phase in aclk cycles, a long half gives the panel time to settle
  task automatic send(input logic [63:0] bits, input int n, input int half);
    falls = 0;
    for (int i = n - 1; i >= 0; i--) begin
      sdata <= bits[i];
      repeat (half) @(posedge aclk);
      sclk <= 1'b1;
      repeat (half) @(posedge aclk);
      sclk <= 1'b0;
      falls++;
    end
    sdata <= ~bits[0]; // released line must not keep a stale level
  endtask
endmodule // tas_host_model

//--- tb/tas_touch_seq_asserts.sv
// checker: output relations of the touch switch sequencer
`timescale 1ns/1ps
`include "tas_defs.vh"
module tas_touch_seq_asserts (
  input wire aclk, // clock
  input wire aresetn, // reset, active low
  input wire track_en, // tracking
  input wire [2:0] mux_sel, // channel
  input wire drv_xp, // x+ driver
  input wire drv_xn, // x- driver
  input wire drv_yp, // y+ driver
  input wire drv_yn, // y- driver
  input wire [1:0] ref_pos_sel, // +ref node
  input wire [1:0] ref_neg_sel, // -ref node
  input wire bat_div_en, // divider
  input wire temp_bias_base, // base diode
  input wire temp_bias_mult, // multiplied diode
  input wire int_ref_en, // reference on
  input wire reference_disconnect_switch // switch closed
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // driver nibble {x+, x-, y+, y-}; se marks a single-ended reference
  wire [3:0] drv = {drv_xp, drv_xn, drv_yp, drv_yn};
  wire se = ref_pos_sel == `TAS_REFP_VREF;
  property p_pwr_rst; $rose(aresetn) |-> int_ref_en && reference_disconnect_switch; endproperty
  a_pwr_rst: assert property (p_pwr_rst) else $error("reference off after reset");
  property p_sw_open; !int_ref_en |-> !reference_disconnect_switch; endproperty
  a_sw_open: assert property (p_sw_open) else $error("switch closed, reference off");
  property p_bat; bat_div_en |-> track_en && mux_sel == `TAS_CH_BAT; endproperty
  a_bat: assert property (p_bat) else $error("divider on outside battery sample");
  property p_temp;
    temp_bias_base || temp_bias_mult |->
      track_en && mux_sel == (temp_bias_base ? `TAS_CH_TEMP0 : `TAS_CH_TEMP1) && !(temp_bias_base && temp_bias_mult);
  endproperty
  a_temp: assert property (p_temp) else $error("diode bias misplaced");
  property p_se_y;
    track_en && mux_sel == `TAS_CH_XPOS && se |-> drv == 4'h3 && ref_neg_sel == `TAS_REFN_GND;
  endproperty
  a_se_y: assert property (p_se_y) else $error("single-ended y setup wrong");
  property p_ratio_y;
    track_en && mux_sel == `TAS_CH_XPOS && !se |-> ref_pos_sel == `TAS_REFP_YP && ref_neg_sel == `TAS_REFN_YN;
  endproperty
  a_ratio_y: assert property (p_ratio_y) else $error("ratiometric refs wrong");
  property p_se_off; $fell(track_en) && se |-> drv == 4'h0; endproperty
  a_se_off: assert property (p_se_off) else $error("drivers on after acquisition");
  property p_ratio_on; $fell(track_en) && !se |=> $stable(drv) [*8]; endproperty
  a_ratio_on: assert property (p_ratio_on) else $error("drivers changed in conversion");
  property p_hold; track_en && $past(track_en) |-> $stable({mux_sel, ref_pos_sel, ref_neg_sel}); endproperty
  a_hold: assert property (p_hold) else $error("setup changed in acquisition");
endmodule // tas_touch_seq_asserts

//--- tb/test_tas_touch_seq.sv
// self-checking bench for the touch switch sequencer
`timescale 1ns/1ps
`include "tas_defs.vh"
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module test_tas_touch_seq;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, ref_pos_sel, ref_neg_sel;
  wire [31:0] s_axi_rdata;
  wire [2:0] mux_sel;
  wire serial_conversion_clock, serial_data_in, track_en, drv_xp, drv_xn, drv_yp, drv_yn;
  wire bat_div_en, temp_bias_base, temp_bias_mult, int_ref_en, reference_disconnect_switch;
  wire [3:0] drv = {drv_xp, drv_xn, drv_yp, drv_yn};
  int err_count = 0;
  int check_count = 0;
  logic [31:0] d;
  logic [1:0] r;
  always #50 aclk = ~aclk;
  tas_touch_seq tas_touch_seq_inst (.*);
  tas_host_model tas_host_model_inst (.aclk(aclk), .sclk(serial_conversion_clock), .sdata(serial_data_in));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic tmo(input int t);
    if (t >= 2000) begin
      err_count++;
      $display("CHECK FAILED %0t timeout", $time);
      report_and_stop();
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] st, output logic [1:0] rs);
    int t;
    logic got;
    got = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (t = 0; t < 2000 && !got; t++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      got = (s_axi_bvalid === 1'b1);
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(got ? 0 : 2000);
    // one quiet edge so the next call never re-drives a signal just dropped
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int t;
    logic got;
    got = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (t = 0; t < 2000 && !got; t++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      got = (s_axi_rvalid === 1'b1);
    end
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(got ? 0 : 2000);
    @(posedge aclk);
  endtask
  task automatic wt(input logic v);
    int t;
    for (t = 0; t < 2000 && track_en !== v; t++) @(posedge aclk);
    tmo(t);
  endtask
  task automatic s_reset;
    rd(`TAS_REG_CTRL, d, r);
    `CHK(d[0], `TAS_CTRL_RST, "enable reset")
    rd(`TAS_REG_WORD, d, r);
    `CHK(d[9:8], `TAS_PD_RST, "power bits reset")
    rd(`TAS_REG_COUNT, d, r);
    `CHK(d[15:0], 16'h0000, "count reset")
    rd(8'h10, d, r);
    `CHK({r, d}, {`TAS_RESP_SLVERR, 32'h0}, "unmapped read")
    `CHK({int_ref_en, reference_disconnect_switch}, 2'h3, "reference at reset")
  endtask
  // masked, read-only and unmapped writes, then a frame while disabled
  task automatic s_regs;
    wr(`TAS_REG_CTRL, 32'h0, 4'h0, r);
    rd(`TAS_REG_CTRL, d, r);
    `CHK(d[0], 1'b1, "masked write")
    wr(`TAS_REG_STATUS, 32'hffffffff, 4'hf, r);
    `CHK(r, `TAS_RESP_OKAY, "read-only write")
    wr(8'h20, 32'h0, 4'hf, r);
    `CHK(r, `TAS_RESP_SLVERR, "unmapped write")
    wr(`TAS_REG_CTRL, 32'h0, 4'hf, r);
    tas_host_model_inst.send({8'h94, 16'h0}, 24, 4);
    repeat (6) @(posedge aclk);
    rd(`TAS_REG_COUNT, d, r);
    `CHK({int_ref_en, d[15:0]}, {1'b1, 16'h0000}, "disabled start")
    wr(`TAS_REG_CTRL, 32'h1, 4'hf, r);
  endtask
  // single-ended y with leading idle zeros
  task automatic s_single;
    fork
      tas_host_model_inst.send({4'h0, 8'h94, 20'h0}, 32, 4);
      begin
        wt(1'b1);
        `CHK(tas_host_model_inst.falls, 10, "tracking edge")
        `CHK({mux_sel, drv, ref_pos_sel, ref_neg_sel}, {`TAS_CH_XPOS, 4'h3, 4'h0}, "se setup")
        wt(1'b0);
        `CHK(tas_host_model_inst.falls, 13, "acquisition length")
        `CHK(drv, 4'h0, "se drivers off")
      end
    join
    repeat (6) @(posedge aclk);
    `CHK({int_ref_en, reference_disconnect_switch}, 2'h0, "reference off")
    rd(`TAS_REG_COUNT, d, r);
    `CHK(d[15:0], 16'h0001, "one conversion")
  endtask
  // two overlapped fifteen-clock differential words
  task automatic s_back;
    int k;
    int bad;
    int t;
    logic p;
    fork
      tas_host_model_inst.send({8'h90, 7'h0, 8'h90, 25'h0}, 48, 4);
      begin
        wt(1'b1);
        k = 0;
        bad = 0;
        p = 1'b1;
        for (t = 0; t < 2000 && k < 3; t++) begin
          @(posedge aclk);
          if (track_en !== p) k++;
          p = track_en;
          if (drv !== 4'h3) bad++;
        end
        tmo(t);
        `CHK(bad, 0, "drivers gap")
      end
    join
    repeat (6) @(posedge aclk);
    `CHK(drv, 4'h0, "drivers off after frame")
    rd(`TAS_REG_COUNT, d, r);
    `CHK(d[15:0], 16'h0003, "overlapped conversions counted")
  endtask
  // slow clock, ratiometric y+ with both power bits set
  task automatic s_ratio;
    fork
      tas_host_model_inst.send({8'hd3, 20'h0}, 28, 10);
      begin
        wt(1'b1);
        `CHK({drv, ref_pos_sel, ref_neg_sel}, {4'hc, `TAS_REFP_XP, `TAS_REFN_XN}, "ratio setup")
        wt(1'b0);
        `CHK(drv, 4'hc, "ratio drivers on")
      end
    join
    repeat (6) @(posedge aclk);
    `CHK({drv, int_ref_en}, {4'hc, 1'b1}, "drivers held idle")
  endtask
  task automatic s_aux;
    logic [7:0] w [3] = '{8'h86, 8'hf6, 8'hac};
    logic [2:0] e [3] = '{3'h2, 3'h1, 3'h4};
    repeat (100) @(posedge aclk);
    for (int i = 0; i < 3; i++) begin
      fork
        tas_host_model_inst.send({w[i], 16'h0}, 24, 4);
        begin
          wt(1'b1);
          `CHK({bat_div_en, temp_bias_base, temp_bias_mult}, e[i], "aux bias on")
          wt(1'b0);
          `CHK({bat_div_en, temp_bias_base, temp_bias_mult}, 3'h0, "aux bias off")
        end
      join
    end
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    s_reset();
    s_regs();
    s_single();
    s_back();
    s_ratio();
    s_aux();
    report_and_stop();
  end
endmodule // test_tas_touch_seq
bind tas_touch_seq tas_touch_seq_asserts tas_touch_seq_asserts_inst (.*);
